/* File: rtl/lintc_defines.svh */
`ifndef LINTC_DEFINES_SVH
`define LINTC_DEFINES_SVH

`define LINTC_CLK_MHZ            50
// Times in their own units, figures as specified
`define LINTC_DOM_MIN_MS         650
`define LINTC_DOM_NOM_MS         1000
`define LINTC_DOM_MAX_MS         1350
`define LINTC_DEGLITCH_MIN_US    42
`define LINTC_DEGLITCH_NOM_US    70
`define LINTC_DEGLITCH_MAX_US    95
`define LINTC_REPORT_MIN_NS      9000
`define LINTC_REPORT_NOM_NS      13000
`define LINTC_REPORT_MAX_NS      17000
// Cycle counts derived from the clock rate
`define LINTC_DOM_CYC      (`LINTC_DOM_NOM_MS * 1000 * `LINTC_CLK_MHZ)
`define LINTC_DEGLITCH_CYC (`LINTC_DEGLITCH_NOM_US * `LINTC_CLK_MHZ)
`define LINTC_REPORT_CYC   ((`LINTC_REPORT_NOM_NS * `LINTC_CLK_MHZ) / 1000)
// Slew setting codes
`define LINTC_SLEW_NORMAL  2'h0
`define LINTC_SLEW_SLOW    2'h1
`define LINTC_SLEW_FAST    2'h2
// Mode codes
`define LINTC_MODE_NORMAL  2'h0
`define LINTC_MODE_NORMREQ 2'h1
`define LINTC_MODE_STOP    2'h2
`define LINTC_MODE_SLEEP   2'h3

`endif

/* File: rtl/lintc_pkg.sv */
package lintc_pkg;
  typedef enum logic [1:0] {
    LINTC_NORMAL,
    LINTC_NORMREQ,
    LINTC_STOP,
    LINTC_SLEEP
  } lintc_mode_type;

  typedef enum logic [1:0] {
    LINTC_SLEW_NORM,
    LINTC_SLEW_SLOW10K,
    LINTC_SLEW_FASTPROG
  } lintc_slew_type;

  typedef enum {
    LINTC_W_IDLE,
    LINTC_W_FILTER,
    LINTC_W_REPORT,
    LINTC_W_HOLD
  } lintc_wake_type;
endpackage

/* File: rtl/lintc_sync.sv */
`timescale 1ns/1ps
module lintc_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Level in and out
  input  wire logic din,
  output logic      dout
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  // Resets to recessive so no false dominant appears
  always_comb begin
    meta_d = din;
    sync_d = meta_q;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign dout = sync_q;
endmodule

/* File: rtl/lintc_top.sv */
`timescale 1ns/1ps
`include "lintc_defines.svh"
// Behaviour
// - The receive output is low while the bus reads dominant and high while recessive.
// - A low transmit input drives the bus dominant and a high one leaves it recessive.
// - An undriven transmit input counts as high, keeping the bus recessive.
// - Transmit and receive work only in the run and post-reset request modes.
// - A transmit input held dominant for the stuck delay disables the driver.
// - In both low-power modes a wake needs the bus dominant past the deglitch time.
// - In the regulated low-power mode a wake pulls the interrupt low after the report delay.
// - Normal, slow and fast programming slew settings are selectable.
// - The interrupt stays low until the controller acknowledges the status read.
// - A wake from the unpowered low-power mode is reported by a reset request instead.
// - Configuration arrives as register-level inputs; traffic uses only transmit and receive.
module lintc_top
  import lintc_pkg::*;
#(
  parameter int unsigned DOM_CYC    = `LINTC_DOM_CYC,
  parameter int unsigned REPORT_CYC = `LINTC_REPORT_CYC
) (
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           rst,
  // Controller side
  input  wire logic           txd,
  input  wire logic           txd_driven,
  output logic                rxd,
  // Configuration from the serial port block
  input  wire lintc_mode_type mode,
  input  wire lintc_slew_type slew_sel,
  input  wire logic           irq_ack,
  // Bus side
  input  wire logic           bus_dominant,
  output logic                bus_drive,
  output logic [1:0]          slew_out,
  // Status and events
  output logic                stuck_dominant,
  output logic                wake_flag,
  output logic                irq_n,
  output logic                wake_reset_req
);
  localparam int unsigned DEGL_CYC = `LINTC_DEGLITCH_CYC;
  localparam int unsigned CW       = 26;

  logic    tx_raw;
  logic    tx_s;
  logic    bus_rec_s;
  logic    active;
  lintc_wake_type ws_q, ws_d;
  logic [CW-1:0] dom_cnt_q, dom_cnt_d;
  logic [CW-1:0] wk_cnt_q, wk_cnt_d;
  logic    stuck_q, stuck_d;
  logic    drive_q, drive_d;
  logic    rxd_q, rxd_d;
  logic [1:0] slew_q, slew_d;
  logic    wflag_q, wflag_d;
  logic    irq_q, irq_d;
  logic    rreq_q, rreq_d;

  function automatic logic [CW-1:0] cnt_up(input logic [CW-1:0] c);
    cnt_up = (c == {CW{1'b1}}) ? c : c + 1'b1;
  endfunction

  // Run and post-reset request modes only
  function automatic logic run_mode(input lintc_mode_type m);
    run_mode = (m == LINTC_NORMAL) || (m == LINTC_NORMREQ);
  endfunction

  // Code 3 is unused and falls back to the normal edge rate
  function automatic logic [1:0] slew_code(input lintc_slew_type s);
    unique case (s)
      LINTC_SLEW_SLOW10K:  slew_code = `LINTC_SLEW_SLOW;
      LINTC_SLEW_FASTPROG: slew_code = `LINTC_SLEW_FAST;
      default:             slew_code = `LINTC_SLEW_NORMAL;
    endcase
  endfunction

  assign tx_raw = txd_driven ? txd : 1'b1;

  lintc_sync u_tx_sync (
    .clk  (clk),
    .rst  (rst),
    .din  (tx_raw),
    .dout (tx_s)
  );

  lintc_sync u_bus_sync (
    .clk  (clk),
    .rst  (rst),
    .din  (~bus_dominant),
    .dout (bus_rec_s)
  );

  assign active = run_mode(mode);

  // Transmit path and stuck-dominant guard
  always_comb begin
    dom_cnt_d = dom_cnt_q;
    stuck_d   = stuck_q;
    if (!active || tx_s) begin
      dom_cnt_d = '0;
      stuck_d   = 1'b0; // Released by recessive transmit input or by leaving the run modes
    end else begin
      dom_cnt_d = cnt_up(dom_cnt_q);
      if (dom_cnt_q >= CW'(DOM_CYC - 1)) begin
        stuck_d = 1'b1;
      end
    end
    drive_d = active && !tx_s && !stuck_d;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dom_cnt_q <= '0;
      stuck_q   <= 1'b0;
      drive_q   <= 1'b0;
    end else begin
      dom_cnt_q <= dom_cnt_d;
      stuck_q   <= stuck_d;
      drive_q   <= drive_d;
    end
  end

  // Receive output, forced recessive while the transceiver is off
  always_comb begin
    rxd_d = active ? bus_rec_s : 1'b1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxd_q <= 1'b1;
    end else begin
      rxd_q <= rxd_d;
    end
  end

  // Slew only shapes edges, so it follows the input in every mode
  always_comb begin
    slew_d = slew_code(slew_sel);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slew_q <= `LINTC_SLEW_NORMAL;
    end else begin
      slew_q <= slew_d;
    end
  end

  // Wake detection in low-power modes
  always_comb begin
    ws_d     = ws_q;
    wk_cnt_d = wk_cnt_q;
    wflag_d  = wflag_q;
    irq_d    = irq_q;
    rreq_d   = 1'b0;
    if (irq_ack) begin
      irq_d   = 1'b1;
      wflag_d = 1'b0;
    end
    unique case (ws_q)
      LINTC_W_IDLE: begin
        wk_cnt_d = '0;
        if (!active && !bus_rec_s) begin
          ws_d = LINTC_W_FILTER;
        end
      end
      LINTC_W_FILTER: begin
        wk_cnt_d = cnt_up(wk_cnt_q);
        if (active || bus_rec_s) begin
          ws_d = LINTC_W_IDLE;
        end else if (wk_cnt_q >= CW'(DEGL_CYC - 1)) begin
          wflag_d = 1'b1;
          if (mode == LINTC_SLEEP) begin
            rreq_d = 1'b1;
            ws_d   = LINTC_W_HOLD;
          end else begin
            ws_d = LINTC_W_REPORT;
          end
        end
      end
      LINTC_W_REPORT: begin
        // Report delay counted from threshold crossing, covered by deglitch time
        // Limitation: a report delay below the deglitch time is met late
        wk_cnt_d = cnt_up(wk_cnt_q);
        if (wk_cnt_q >= CW'(DEGL_CYC + REPORT_CYC - 1) || REPORT_CYC <= DEGL_CYC) begin
          irq_d = 1'b0;
          ws_d  = LINTC_W_HOLD;
        end
      end
      LINTC_W_HOLD: begin
        wk_cnt_d = '0;
        if (bus_rec_s) begin
          ws_d = LINTC_W_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ws_q     <= LINTC_W_IDLE;
      wk_cnt_q <= '0;
      wflag_q  <= 1'b0;
      irq_q    <= 1'b1;
      rreq_q   <= 1'b0;
    end else begin
      ws_q     <= ws_d;
      wk_cnt_q <= wk_cnt_d;
      wflag_q  <= wflag_d;
      irq_q    <= irq_d;
      rreq_q   <= rreq_d;
    end
  end

  assign rxd            = rxd_q;
  assign bus_drive      = drive_q;
  assign slew_out       = slew_q;
  assign stuck_dominant = stuck_q;
  assign wake_flag      = wflag_q;
  assign irq_n          = irq_q;
  assign wake_reset_req = rreq_q;
endmodule

/* File: test/lintc_top_asserts.sv */
`timescale 1ns/1ps
module lintc_top_asserts
  import lintc_pkg::*;
#(
  parameter int unsigned DOM_CYC = 100
) (
  // Clock and reset
  input wire logic           clk,
  input wire logic           rst,
  // Controller side
  input wire logic           txd,
  input wire logic           txd_driven,
  input wire logic           rxd,
  input wire logic           irq_ack,
  // Configuration
  input wire lintc_mode_type mode,
  input wire lintc_slew_type slew_sel,
  // Bus side and status
  input wire logic           bus_dominant,
  input wire logic           bus_drive,
  input wire logic           stuck_dominant,
  input wire logic           wake_flag,
  input wire logic           irq_n,
  input wire logic           wake_reset_req,
  input wire logic [1:0]     slew_out
);
  localparam int WAKE_MIN = 3500;
  logic [31:0] drv_q, drv_d, bus_q, bus_d;
  // Run lengths of drive and bus level
  always_comb begin
    drv_d = bus_drive ? drv_q + 32'h1 : 32'h0;
    bus_d = bus_dominant ? bus_q + 32'h1 : 32'h0;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      drv_q <= 32'h0;
      bus_q <= 32'h0;
    end else begin
      drv_q <= drv_d;
      bus_q <= bus_d;
    end
  end
  default clocking dck @(posedge clk); endclocking
  default disable iff (rst);
  a_rx_level: assert property (
    (mode == LINTC_NORMAL) [*4] |-> rxd == !$past(bus_dominant, 3)) else $error("rxd level");
  a_tx_level: assert property (
    (mode == LINTC_NORMAL) [*4] ##0 !stuck_dominant |-> bus_drive == !$past(txd | !txd_driven, 3))
    else $error("drive level");
  a_stuck_trip: assert property (
    $rose(stuck_dominant) |-> !bus_drive && drv_q inside {[DOM_CYC - 2:DOM_CYC + 2]})
    else $error("stuck timing");
  a_wake_filter: assert property (
    $rose(wake_flag) |-> bus_q >= WAKE_MIN) else $error("wake too early");
  a_irq_report: assert property (
    $rose(wake_flag) && mode == LINTC_STOP |-> ##[0:2] !irq_n) else $error("no irq");
  a_irq_hold: assert property (
    !irq_n && !irq_ack && !$past(irq_ack) |=> !irq_n) else $error("irq released");
  a_sleep_reset: assert property (
    $rose(wake_flag) && mode == LINTC_SLEEP |-> ##[0:1] wake_reset_req && irq_n)
    else $error("no reset request");
  a_slew_map: assert property (
    $stable(slew_sel) |-> slew_out == (slew_sel == LINTC_SLEW_FASTPROG ? 2'h2
      : {1'h0, slew_sel == LINTC_SLEW_SLOW10K})) else $error("slew code");
  a_idle_gate: assert property (
    mode inside {LINTC_STOP, LINTC_SLEEP} |=> !bus_drive && rxd) else $error("idle gate");
endmodule
bind lintc_top lintc_top_asserts #(.DOM_CYC(DOM_CYC)) i_chk (.clk, .rst, .txd, .txd_driven,
  .rxd, .irq_ack, .mode, .slew_sel, .bus_dominant, .bus_drive, .stuck_dominant, .wake_flag,
  .irq_n, .wake_reset_req, .slew_out);

/* File: test/lintc_bus_model.sv */
`timescale 1ns/1ps
module lintc_bus_model (
  // Drivers on the wire
  input  wire logic dut_drive,
  input  wire logic node_drive,
  // Sensed level
  output logic      bus_dominant
);
  // Pull-up keeps it recessive unless a node pulls
  assign bus_dominant = dut_drive | node_drive;
endmodule

/* File: test/lintc_top_bench.sv */
`timescale 1ns/1ps
module lintc_top_bench;
  import lintc_pkg::*;
  localparam int unsigned DOM = 100;
  logic clk = 1'h0, rst = 1'h1, txd = 1'h1, txd_driven = 1'h1, irq_ack = 1'h0, node = 1'h0;
  logic seen = 1'h0, rxd, bus_dominant, bus_drive, stuck_dominant, wake_flag, irq_n;
  logic wake_reset_req;
  logic [1:0] slew_out;
  lintc_mode_type mode = LINTC_NORMAL;
  lintc_slew_type slew_sel = LINTC_SLEW_NORM;
  int fail_count = 0, comparisons = 0;
  always #10 clk = ~clk;
  // Pulse lasts one cycle, so latch it
  always @(negedge clk) if (wake_reset_req === 1'h1) seen <= 1'h1;
  lintc_bus_model i_bus (.dut_drive(bus_drive), .node_drive(node), .bus_dominant);
  lintc_top #(.DOM_CYC(DOM)) i_dut (.clk, .rst, .txd, .txd_driven, .rxd, .mode, .slew_sel,
    .irq_ack, .bus_dominant, .bus_drive, .slew_out, .stuck_dominant, .wake_flag, .irq_n,
    .wake_reset_req);
  task chk(string n, logic [1:0] s, logic [1:0] e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task wait_wake(int lim);
    repeat (lim) if (wake_flag !== 1'h1) cyc(1);
    if (wake_flag !== 1'h1) begin
      fail_count++;
      print_verdict;
    end
  endtask
  task t_drive;
    txd = 1'h0;
    cyc(8);
    chk("drive", bus_drive, 2'h1);
    chk("rxd", rxd, 2'h0);
    txd_driven = 1'h0;
    cyc(8);
    chk("float", bus_drive, 2'h0);
    mode = LINTC_NORMREQ;
    txd_driven = 1'h1;
    txd = 1'h1;
    node = 1'h1;
    cyc(8);
    chk("rxd_node", rxd, 2'h0);
    node = 1'h0;
    for (int k = 0; k < 4; k++) begin
      slew_sel = lintc_slew_type'(k);
      cyc(3);
      chk("slew", slew_out, k == 2 ? 2'h2 : k == 1 ? 2'h1 : 2'h0);
    end
  endtask
  task t_stuck;
    mode = LINTC_NORMAL;
    txd = 1'h0;
    cyc(DOM - 10);
    chk("pre_trip", stuck_dominant, 2'h0);
    cyc(20);
    chk("stuck", stuck_dominant, 2'h1);
    chk("drv_off", bus_drive, 2'h0);
    txd = 1'h1;
    cyc(8);
    chk("clear", stuck_dominant, 2'h0);
  endtask
  task t_stop;
    mode = LINTC_STOP;
    txd = 1'h0;
    node = 1'h1;
    cyc(3000);
    chk("tx_gate", bus_drive, 2'h0);
    chk("rx_gate", rxd, 2'h1);
    node = 1'h0;
    txd = 1'h1;
    cyc(8);
    chk("glitch", wake_flag, 2'h0);
    node = 1'h1;
    cyc(3400);
    chk("early", wake_flag, 2'h0);
    wait_wake(400);
    cyc(2);
    chk("irq", irq_n, 2'h0);
    node = 1'h0;
    cyc(20);
    chk("irq_hold", irq_n, 2'h0);
    irq_ack = 1'h1;
    cyc(1);
    irq_ack = 1'h0;
    cyc(2);
    chk("irq_free", irq_n, 2'h1);
  endtask
  task t_sleep;
    mode = LINTC_SLEEP;
    node = 1'h1;
    wait_wake(3800);
    cyc(2);
    chk("rst_req", seen, 2'h1);
    chk("no_irq", irq_n, 2'h1);
    node = 1'h0;
  endtask
  task t_reset;
    rst = 1'h1;
    cyc(2);
    chk("rst_flag", wake_flag, 2'h0);
    chk("rst_irq", irq_n, 2'h1);
    chk("rst_drive", bus_drive, 2'h0);
    chk("rst_rxd", rxd, 2'h1);
    rst = 1'h0;
    cyc(4);
    chk("rel_flag", wake_flag, 2'h0);
  endtask
  initial begin
    cyc(5);
    rst = 1'h0;
    t_drive;
    t_stuck;
    t_stop;
    t_sleep;
    t_reset;
    print_verdict;
  end
endmodule
